// file: rtl/lmr_pkg.sv
// constants for the line monitor readback register group
package lmr_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] LOOP_VOLTAGE_IDX = 8'h4e;
  localparam logic [7:0] LOOP_CURRENT_IDX = 8'h4f;
  localparam logic [7:0] TIP_VOLTAGE_IDX = 8'h50;
  localparam logic [7:0] RING_VOLTAGE_IDX = 8'h51;
  localparam logic [7:0] BATTERY_A_IDX = 8'h52;
  localparam logic [7:0] BATTERY_B_IDX = 8'h53;
  localparam logic [7:0] TRANSISTOR_ONE_IDX = 8'h54;
  localparam logic [7:0] TRANSISTOR_TWO_IDX = 8'h55;
  // control register holding the extended battery feed enable
  localparam logic [7:0] FEED_CTRL_IDX = 8'h60;
  localparam int FEED_ENABLE_BIT = 0;
  // field layout of the signed loop registers
  localparam int SIGN_BIT = 6;
  localparam int MAG_W = 6;
  // reset value of every monitor and control register
  localparam logic [7:0] MONITOR_RESET = 8'h00;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage : lmr_pkg

// file: rtl/lmr_top.sv
// line monitor readback registers behind an axi4-lite slave
//
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/1ns
module lmr_top
  import lmr_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic clk,
  input wire logic rst,
  // measurement converter sample, taken when meas_valid is high
  input wire logic meas_valid,
  input wire logic loop_voltage_sign,
  input wire logic [5:0] loop_voltage_magnitude,
  input wire logic loop_current_sign,
  input wire logic [5:0] loop_current_magnitude,
  input wire logic [7:0] tip_voltage_reading,
  input wire logic [7:0] ring_voltage_reading,
  input wire logic [7:0] battery_reading_a,
  input wire logic [7:0] battery_reading_b,
  input wire logic [7:0] transistor_one_current,
  input wire logic [7:0] transistor_two_current,
  input wire logic [7:0] extended_battery_offset,
  // copy of the feed enable control bit
  output logic extended_battery_feed_enable,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // monitor snapshot registers
  logic [7:0] loop_voltage_ff; // sign and magnitude
  logic [7:0] loop_current_ff; // direction and magnitude
  logic [7:0] tip_ff; // tip to ground code
  logic [7:0] ring_ff; // ring to ground code
  logic [7:0] bat_a_ff; // battery code, first copy
  logic [7:0] bat_b_ff; // battery code, second copy
  logic [7:0] q1_ff; // transistor one current
  logic [7:0] q2_ff; // transistor two current
  logic feed_en_ff; // extended battery feed enable
  logic [7:0] nxt_q1; // corrected transistor one code
  logic [7:0] nxt_q2; // corrected transistor two code

  // write channel state
  logic aw_held_ff; // write address taken, waiting for data
  logic [ADDR_W-1:0] awaddr_ff;
  logic w_held_ff; // write data taken, waiting for address
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_fire; // both halves present, commit the write
  logic [7:0] wr_idx;

  // read channel state
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [7:0] rd_idx;
  logic [7:0] rd_val;
  logic rd_hit;

  // strip the offset current, flooring at zero rather than wrapping
  // a wrapped difference would report a near full-scale current for an idle
  // transistor, which is worse than losing the last few counts near zero
  function automatic logic [7:0] lmr_strip(input logic [7:0] raw, input logic [7:0] off,
                                          input logic en);
    if (!en)
      lmr_strip = raw;
    else if (raw > off)
      lmr_strip = raw - off;
    else
      lmr_strip = 8'h00;
  endfunction : lmr_strip

  always_comb
  begin
    nxt_q1 = lmr_strip(transistor_one_current, extended_battery_offset, feed_en_ff);
    nxt_q2 = lmr_strip(transistor_two_current, extended_battery_offset, feed_en_ff);
  end

  // snapshot every reading on the same edge so a read never mixes samples
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loop_voltage_ff <= MONITOR_RESET;
      loop_current_ff <= MONITOR_RESET;
      tip_ff <= MONITOR_RESET;
      ring_ff <= MONITOR_RESET;
      bat_a_ff <= MONITOR_RESET;
      bat_b_ff <= MONITOR_RESET;
      q1_ff <= MONITOR_RESET;
      q2_ff <= MONITOR_RESET;
    end
    else if (meas_valid)
    begin
      loop_voltage_ff <= {1'b0, loop_voltage_sign, loop_voltage_magnitude};
      loop_current_ff <= {1'b0, loop_current_sign, loop_current_magnitude};
      tip_ff <= tip_voltage_reading;
      ring_ff <= ring_voltage_reading;
      bat_a_ff <= battery_reading_a;
      bat_b_ff <= battery_reading_b;
      q1_ff <= nxt_q1;
      q2_ff <= nxt_q2;
    end
  end

  // address and data may arrive in either order; each is held until both are in
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_idx = awaddr_ff[9:2];

  // write address capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_held_ff <= 1'b0;
  end

  // write data capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held_ff <= 1'b1;
      wdata_ff <= s_axi_wdata;
      wstrb_ff <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_held_ff <= 1'b0;
  end

  // only the control word is writable; monitor words accept and drop the data
  always_ff @(posedge clk)
  begin
    if (rst)
      feed_en_ff <= 1'b0;
    else if (wr_fire && wr_idx == FEED_CTRL_IDX && wstrb_ff[0]
             && awaddr_ff[ADDR_W-1:10] == '0)
      feed_en_ff <= wdata_ff[FEED_ENABLE_BIT];
  end

  // write response: monitor words answer okay, unmapped words decode error
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_ff <= 1'b1;
      if (awaddr_ff[ADDR_W-1:10] == '0 && (wr_idx == FEED_CTRL_IDX
          || (wr_idx >= LOOP_VOLTAGE_IDX && wr_idx <= TRANSISTOR_TWO_IDX)))
        bresp_ff <= RESP_OKAY;
      else
        bresp_ff <= RESP_DECERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // read decode; upper address bits must be zero for a hit
  assign rd_idx = s_axi_araddr[9:2];
  always_comb
  begin
    rd_hit = (s_axi_araddr[ADDR_W-1:10] == '0);
    case (rd_idx)
      LOOP_VOLTAGE_IDX: rd_val = loop_voltage_ff;
      LOOP_CURRENT_IDX: rd_val = loop_current_ff;
      TIP_VOLTAGE_IDX: rd_val = tip_ff;
      RING_VOLTAGE_IDX: rd_val = ring_ff;
      BATTERY_A_IDX: rd_val = bat_a_ff;
      BATTERY_B_IDX: rd_val = bat_b_ff;
      TRANSISTOR_ONE_IDX: rd_val = q1_ff;
      TRANSISTOR_TWO_IDX: rd_val = q2_ff;
      FEED_CTRL_IDX: rd_val = {7'h00, feed_en_ff};
      default:
      begin
        rd_val = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  // one read in flight; the answer follows the address by one edge
  // read data is frozen at the address edge so a later sample cannot tear it
  assign s_axi_arready = !rvalid_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_val};
      rresp_ff <= rd_hit ? RESP_OKAY : RESP_DECERR;
    end
    else if (s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign extended_battery_feed_enable = feed_en_ff;

  // checks on the sampling and register behaviour
  default clocking dc @(posedge clk); endclocking
  default disable iff (rst);

  sequence sample_s;
    meas_valid;
  endsequence

  sequence quiet_s;
    !meas_valid;
  endsequence

  loop_sign_a: assert property (sample_s |=> loop_voltage_ff[6] == $past(loop_voltage_sign))
    else $error("loop voltage sign not captured");
  loop_mag_a: assert property (sample_s |=> loop_voltage_ff[7] == 1'b0
    && loop_voltage_ff[5:0] == $past(loop_voltage_magnitude))
    else $error("loop voltage magnitude wrong");
  curr_sign_a: assert property (sample_s |=> loop_current_ff[6] == $past(loop_current_sign))
    else $error("loop current direction not captured");
  curr_mag_a: assert property (sample_s |=> loop_current_ff[7] == 1'b0
    && loop_current_ff[5:0] == $past(loop_current_magnitude))
    else $error("loop current magnitude wrong");
  tip_code_a: assert property (sample_s |=> tip_ff == $past(tip_voltage_reading))
    else $error("tip code not captured");
  ring_code_a: assert property (sample_s |=> ring_ff == $past(ring_voltage_reading))
    else $error("ring code not captured");
  battery_code_a: assert property (sample_s |=> bat_a_ff == $past(battery_reading_a)
    && bat_b_ff == $past(battery_reading_b))
    else $error("battery code not captured");
  q1_plain_a: assert property (sample_s ##0 !feed_en_ff
    |=> q1_ff == $past(transistor_one_current))
    else $error("transistor one code wrong");
  q2_plain_a: assert property (sample_s ##0 !feed_en_ff
    |=> q2_ff == $past(transistor_two_current))
    else $error("transistor two code wrong");
  offset_strip_a: assert property (sample_s ##0 feed_en_ff
    ##0 (transistor_one_current > extended_battery_offset)
    |=> q1_ff == 8'($past(transistor_one_current) - $past(extended_battery_offset)))
    else $error("offset current not removed");
  // a reading at or below the offset must report zero, never wrap
  floor_zero_a: assert property (sample_s ##0 feed_en_ff
    ##0 (transistor_two_current <= extended_battery_offset)
    |=> q2_ff == 8'h00)
    else $error("offset subtraction wrapped");
  write_ignored_a: assert property (quiet_s ##0 wr_fire
    |=> $stable(loop_voltage_ff) && $stable(q1_ff) && $stable(tip_ff))
    else $error("write changed a monitor register");
  // a write anywhere but the control word leaves the feed setting alone
  ro_state_a: assert property (wr_fire && wr_idx != FEED_CTRL_IDX
    |=> $stable(feed_en_ff))
    else $error("monitor write changed device state");
  hold_between_a: assert property (quiet_s |=> $stable(loop_current_ff)
    && $stable(ring_ff) && $stable(bat_b_ff) && $stable(q2_ff))
    else $error("monitor changed without a sample");

endmodule : lmr_top

// file: tb/lmr_host.sv
// host model: axi4-lite master reading and writing the monitor group
`timescale 1ns/1ns
module lmr_host
(
  input wire logic clk,
  output logic [11:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [11:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // idle bus at time zero so nothing floats into the slave
  initial
  begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
  end

  // a wait that never ends is a mismatch and stops the run
  task automatic stall();
    testbench.n_fail++;
    testbench.test_done();
  endtask : stall

  // offer address and data together, drop each once taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    {awvalid, wvalid, bready} <= 3'h7;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 50) stall();
  endtask : wr

  // single read; rready held until the answer edge
  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 50) stall();
  endtask : rd
endmodule : lmr_host

// file: tb/testbench.sv
// self-checking bench for the line monitor readback registers
`timescale 1ns/1ns
module testbench;
  import lmr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic meas_valid = 1'b0;
  logic [7:0] m [8] = '{default: 8'h00}; // sample bytes in register order
  logic [7:0] off = 8'h00; // offset current to strip
  logic feed_en;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int n_fail = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;

  lmr_top lmr_top_inst (.clk(clk), .rst(rst), .meas_valid(meas_valid),
    .loop_voltage_sign(m[0][6]), .loop_voltage_magnitude(m[0][5:0]),
    .loop_current_sign(m[1][6]), .loop_current_magnitude(m[1][5:0]),
    .tip_voltage_reading(m[2]), .ring_voltage_reading(m[3]),
    .battery_reading_a(m[4]), .battery_reading_b(m[5]),
    .transistor_one_current(m[6]), .transistor_two_current(m[7]),
    .extended_battery_offset(off), .extended_battery_feed_enable(feed_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  lmr_host lmr_host_inst (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // one compare; four-state so an unknown never matches
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string t);
    cmp_count++;
    if (s !== e)
    begin
      n_fail++;
      $display("BAD %0t %s seen %h want %h", $time, t, s, e);
    end
  endtask : chk

  // read one register by index, expect okay and the byte
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    lmr_host_inst.rd({2'b00, idx, 2'b00}, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "read resp");
    chk(d, {24'h0, e}, "read data");
  endtask : rdchk

  // present a sample for one cycle, wait until it has landed
  task automatic sample(input logic [63:0] v);
    @(posedge clk);
    foreach (m[i]) m[i] <= v[8*i +: 8];
    meas_valid <= 1'b1;
    @(posedge clk);
    meas_valid <= 1'b0;
    @(posedge clk);
  endtask : sample

  // read the whole group, byte i of e belongs to index 0x4e+i
  task automatic all_regs(input logic [63:0] e);
    for (int i = 0; i < 8; i++)
      rdchk(LOOP_VOLTAGE_IDX + 8'(i), e[8*i +: 8]);
  endtask : all_regs

  // write the feed control bit and see the copy follow
  task automatic feed(input logic b);
    logic [1:0] r;
    lmr_host_inst.wr(12'h180, {31'h0, b}, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "feed resp");
    chk({31'h0, feed_en}, {31'h0, b}, "feed copy");
    rdchk(FEED_CTRL_IDX, {7'h0, b});
  endtask : feed

  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : test_done

  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    all_regs(64'h0);
    chk({31'h0, feed_en}, 32'h0, "feed reset");
    rdchk(FEED_CTRL_IDX, 8'h00);
    // full scale, both signs set; bit 7 of the loop words stays clear
    sample(64'hffee_ddcc_bbaa_ffff);
    all_regs(64'hffee_ddcc_bbaa_7f7f);
    sample(64'h1080_0300_ff80_4015);
    all_regs(64'h1080_0300_ff80_4015);
    // writes to a monitor word are accepted and ignored
    lmr_host_inst.wr(12'h138, 32'hffff_ffff, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY}, "ro write");
    all_regs(64'h1080_0300_ff80_4015);
    // inputs moving without a strobe must not leak into the words
    @(posedge clk);
    m[2] <= 8'h55;
    rdchk(TIP_VOLTAGE_IDX, 8'h80);
    // offset stripped while feed is on, floor at zero for transistor two
    feed(1'b1);
    off <= 8'h30;
    sample(64'h1080_0300_ff80_4015);
    all_regs(64'h0050_0300_ff80_4015);
    feed(1'b0);
    sample(64'h1080_0300_ff80_4015);
    all_regs(64'h1080_0300_ff80_4015);
    // unmapped place answers decode error, data zero
    lmr_host_inst.rd(12'h200, d, r);
    chk({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped read");
    chk(d, 32'h0, "unmapped data");
    lmr_host_inst.wr(12'h200, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_DECERR}, "unmapped write");
    test_done();
  end
endmodule : testbench
